// [hdl/pma_pkg.sv]
// constants shared by the programmable macrocell array and its pin keeper
package pma_pkg;
  // pin map: index 0 is the clock pin, 1..11 dedicated inputs, 12..21 i/o pins
  localparam int N_PIN = 22;
  localparam int N_DIN = 12;
  localparam int N_IO = 10;
  localparam int PIN_CLK = 0;
  localparam int IO_LO = 12;
  localparam int N_FF = 20;
  localparam int N_AIN = 42;
  localparam int N_AIN_HI = 10;

  // product term pool and its fixed allocation
  localparam int N_PT = 171;
  localparam int CELL_PTS = 12;
  localparam int SUM_LEN_EVEN = 8;
  localparam int SUM_LEN_ODD = 4;
  localparam int PT_CLK0 = 120;
  localparam int PT_RST0 = 140;
  localparam int PT_OE0 = 160;
  localparam int PT_PRE = 170;
  localparam int PT_WORDS_PER = 4;
  localparam int PT_WORDS = 684;

  // register offsets (byte addresses)
  localparam logic [11:0] REG_DT = 12'h000;
  localparam logic [11:0] REG_CKSEL = 12'h004;
  localparam logic [11:0] REG_OCFG = 12'h008;
  localparam logic [11:0] REG_PRELOAD = 12'h00c;
  localparam logic [11:0] REG_PINS = 12'h010;
  localparam logic [11:0] PT_BASE = 12'h400;
  localparam int PT_END = 3760;

  // field positions in the output configuration register
  localparam int OCFG_POL_LO = 0;
  localparam int OCFG_COMB_LO = 10;

  // values after reset
  localparam logic [19:0] DT_RST = 20'h00000;
  localparam logic [19:0] CKSEL_RST = 20'h00000;
  localparam logic [9:0] POL_RST = 10'h000;
  localparam logic [9:0] COMB_RST = 10'h000;
  localparam logic [19:0] FF_RST = 20'h00000;
  localparam logic [31:0] PT_ERASED = 32'hffffffff;
endpackage

// [hdl/pma_pin_if.sv]
// pin levels passed between the array core and the pin keeper
`timescale 1ns/1ps
interface pma_pin_if;
  logic [pma_pkg::N_PIN-1:0] raw;
  logic [pma_pkg::N_PIN-1:0] drv;
  logic [pma_pkg::N_PIN-1:0] lvl;
  modport core (output raw, output drv, input lvl);
  modport keeper (input raw, input drv, output lvl);
endinterface

// [hdl/pma_keeper.sv]
// pin synchronisers and the optional bus-hold keeper
`timescale 1ns/1ps
module pma_keeper #(
  parameter bit KEEPER_EN = 1'b0
) (
  input logic pclk,
  input logic presetn,
  pma_pin_if.keeper pif
);
  logic [pma_pkg::N_PIN-1:0] lvl_m_r;
  logic [pma_pkg::N_PIN-1:0] lvl_s_r;
  logic [pma_pkg::N_PIN-1:0] drv_m_r;
  logic [pma_pkg::N_PIN-1:0] drv_s_r;
  logic [pma_pkg::N_PIN-1:0] held_r;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_m_r <= '0;
      lvl_s_r <= '0;
      drv_m_r <= '0;
      drv_s_r <= '0;
    end else begin
      lvl_m_r <= pif.raw;
      lvl_s_r <= lvl_m_r;
      drv_m_r <= pif.drv;
      drv_s_r <= drv_m_r;
    end
  end

  // the keeper remembers the last level seen while someone drove the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r <= '0;
    end else begin
      held_r <= (drv_s_r & lvl_s_r) | (~drv_s_r & held_r);
    end
  end

  // enable is a build-time choice only; no register can change it
  assign pif.lvl = KEEPER_EN ? ((drv_s_r & lvl_s_r) | (~drv_s_r & held_r)) : lvl_s_r;

  a_keep_hold: assert property (@(posedge pclk) disable iff (!presetn)
    KEEPER_EN |-> ((pif.lvl ^ $past(pif.lvl)) & ~drv_s_r & ~$past(drv_s_r)) == '0)
    else $error("keeper let a floating pin change level");
endmodule // pma_keeper

// [hdl/pma_top.sv]
// programmable macrocell array with apb configuration port
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module pma_top #(
  parameter bit KEEPER_EN = 1'b0
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic pin_clk,
  input logic clk_driven,
  input logic [10:0] in_pin,
  input logic [10:0] in_driven,
  input logic [9:0] io_in,
  input logic [9:0] io_driven,
  output logic [9:0] io_out,
  output logic [9:0] io_oe
);
  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [19:0] dt_r;
  logic [19:0] cksel_r;
  logic [9:0] pol_r;
  logic [9:0] comb_r;
  logic [31:0] pt_mem_r [0:pma_pkg::PT_WORDS-1];
  logic [19:0] q_r;
  logic [19:0] master_r;
  logic [19:0] ckprev_r;
  logic [9:0] io_out_r;
  logic [9:0] io_oe_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic [pma_pkg::N_AIN-1:0] arr_in;
  logic [pma_pkg::N_PT-1:0] pt_val;
  logic [19:0] sum;
  logic [19:0] ck_cur;
  logic [19:0] ck_edge;
  logic [19:0] rst_t;
  logic [9:0] oe_t;
  logic pre_t;
  logic [19:0] ff_nxt;
  logic [19:0] load_m;
  logic [9:0] q_even;
  logic [9:0] sum_even;
  logic [9:0] out_nxt;
  logic acc;
  logic wr;
  logic hit;
  logic preload_we;

  pma_pin_if pins ();

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_pt(input logic [11:0] a);
    return (int'(a) >= int'(pma_pkg::PT_BASE)) && (int'(a) < pma_pkg::PT_END)
      && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    return (a == pma_pkg::REG_DT) || (a == pma_pkg::REG_CKSEL) || (a == pma_pkg::REG_OCFG)
      || (a == pma_pkg::REG_PRELOAD) || (a == pma_pkg::REG_PINS);
  endfunction

  function automatic logic [9:0] pt_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - pma_pkg::PT_BASE;
    return off[11:2];
  endfunction

  // a term is true when every selected true input is high and every
  // selected complement input is low; both set on one input kills it
  function automatic logic pt_eval(
    input logic [pma_pkg::N_AIN-1:0] x,
    input logic [pma_pkg::N_AIN-1:0] t,
    input logic [pma_pkg::N_AIN-1:0] c
  );
    return &((~t | x) & (~c | ~x));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pins: every logic pin is sampled, i/o pins included, own drive counts
  // as driven so the keeper tracks what this device puts out

  assign pins.raw = {io_in, in_pin, pin_clk};
  assign pins.drv = {io_driven | io_oe_r, in_driven, clk_driven};

  pma_keeper #(
    .KEEPER_EN(KEEPER_EN)
  ) u_keeper (
    .pclk(pclk),
    .presetn(presetn),
    .pif(pins.keeper)
  );

  //////////////////////////////////////////////////////////////////////////////
  // product term array

  assign arr_in = {q_r, pins.lvl};

  // words per term: true mask low, true mask high, complement low, high
  generate
    for (genvar k = 0; k < pma_pkg::N_PT; k++) begin : g_pt
      assign pt_val[k] = pt_eval(
        arr_in,
        {pt_mem_r[k*4+1][pma_pkg::N_AIN_HI-1:0], pt_mem_r[k*4]},
        {pt_mem_r[k*4+3][pma_pkg::N_AIN_HI-1:0], pt_mem_r[k*4+2]});
    end
  endgenerate

  // each cell owns twelve terms: eight for its even sum, four for its odd
  generate
    for (genvar s = 0; s < pma_pkg::N_FF; s++) begin : g_sum
      localparam int BASE = (s / 2) * pma_pkg::CELL_PTS + (s % 2) * pma_pkg::SUM_LEN_EVEN;
      localparam int LEN = (s % 2 == 1) ? pma_pkg::SUM_LEN_ODD : pma_pkg::SUM_LEN_EVEN;
      assign sum[s] = |pt_val[BASE +: LEN];
    end
    for (genvar c = 0; c < pma_pkg::N_IO; c++) begin : g_cell
      assign q_even[c] = q_r[2*c];
      assign sum_even[c] = sum[2*c];
    end
  endgenerate

  assign rst_t = pt_val[pma_pkg::PT_RST0 +: pma_pkg::N_FF];
  assign oe_t = pt_val[pma_pkg::PT_OE0 +: pma_pkg::N_IO];
  assign pre_t = pt_val[pma_pkg::PT_PRE];

  //////////////////////////////////////////////////////////////////////////////
  // flop clocking: clock term or pin clock, rising edge seen against pclk

  assign ck_cur = (cksel_r & {20{pins.lvl[pma_pkg::PIN_CLK]}})
    | (~cksel_r & pt_val[pma_pkg::PT_CLK0 +: pma_pkg::N_FF]);
  assign ck_edge = ck_cur & ~ckprev_r;
  assign ff_nxt = (dt_r & (q_r ^ sum)) | (~dt_r & sum);
  assign load_m = ck_edge & ~rst_t & ~{20{pre_t}} & ~{20{preload_we}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ckprev_r <= '0;
    end else begin
      ckprev_r <= ck_cur;
    end
  end

  // master stage is open while the clock is low, so a slow clock term
  // cannot let data race through on the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_r <= pma_pkg::FF_RST;
    end else begin
      master_r <= ~rst_t & (preload_we ? pwdata[19:0]
        : ((ck_cur & master_r) | (~ck_cur & ff_nxt)));
    end
  end

  // slave: reset term beats preload, preload beats the clock edge; the
  // preset only acts on an edge, so the board must raise the clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= pma_pkg::FF_RST;
    end else begin
      q_r <= ~rst_t & (preload_we ? pwdata[19:0]
        : ((ck_edge & {20{pre_t}})
        | (ck_edge & ~{20{pre_t}} & master_r) | (~ck_edge & q_r)));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output cells: even flop or even sum term, through polarity

  assign out_nxt = (comb_r & sum_even) | (~comb_r & q_even);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out_r <= '0;
      io_oe_r <= '0;
    end else begin
      io_out_r <= out_nxt ^ pol_r;
      io_oe_r <= oe_t;
    end
  end

  assign io_out = io_out_r;
  assign io_oe = io_oe_r;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle

  assign acc = psel & penable;
  assign hit = is_pt(paddr) | is_reg(paddr);
  assign wr = acc & pwrite & hit;
  assign preload_we = wr & (paddr == pma_pkg::REG_PRELOAD);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_r <= pma_pkg::DT_RST;
      cksel_r <= pma_pkg::CKSEL_RST;
      pol_r <= pma_pkg::POL_RST;
      comb_r <= pma_pkg::COMB_RST;
    end else if (wr) begin
      case (paddr)
        pma_pkg::REG_DT: dt_r <= pwdata[19:0];
        pma_pkg::REG_CKSEL: cksel_r <= pwdata[19:0];
        pma_pkg::REG_OCFG: begin
          pol_r <= pwdata[pma_pkg::OCFG_POL_LO +: 10];
          comb_r <= pwdata[pma_pkg::OCFG_COMB_LO +: 10];
        end
        default: ;
      endcase
    end
  end

  // erased terms are all-ones masks, which makes every term false
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < pma_pkg::PT_WORDS; i++) begin
        pt_mem_r[i] <= pma_pkg::PT_ERASED;
      end
    end else if (wr && is_pt(paddr)) begin
      pt_mem_r[pt_idx(paddr)] <= pwdata;
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    if (is_pt(paddr)) begin
      rd_nxt = pt_mem_r[pt_idx(paddr)];
    end else begin
      case (paddr)
        pma_pkg::REG_DT: rd_nxt = {12'h000, dt_r};
        pma_pkg::REG_CKSEL: rd_nxt = {12'h000, cksel_r};
        pma_pkg::REG_OCFG: rd_nxt = {12'h000, comb_r, pol_r};
        pma_pkg::REG_PRELOAD: rd_nxt = {12'h000, q_r};
        pma_pkg::REG_PINS: rd_nxt = {10'h000, pins.lvl};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_pwrup_clear: assert property (@(posedge pclk)
    $rose(presetn) |-> (q_r == pma_pkg::FF_RST) && (master_r == pma_pkg::FF_RST))
    else $error("registers not clear after power-up");

  a_pol_out: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((io_out_r ^ $past(pol_r) ^ $past(q_even)) & ~$past(comb_r)) == '0)
    else $error("registered pin level does not follow polarity");

  a_rst_term: assert property (@(posedge pclk) disable iff (!presetn)
    (|rst_t) |=> ((q_r | master_r) & $past(rst_t)) == '0)
    else $error("reset term left master or slave set");

  a_oe_tri: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> io_oe == $past(oe_t))
    else $error("output enable does not follow its term");

  a_sync_preset: assert property (@(posedge pclk) disable iff (!presetn)
    (pre_t && !preload_we && |(ck_edge & ~rst_t)) |=> (~q_r & $past(ck_edge & ~rst_t)) == '0)
    else $error("preset on clock edge did not set flop");

  a_dff_load: assert property (@(posedge pclk) disable iff (!presetn)
    (|load_m) |=> ((q_r ^ $past(master_r)) & $past(load_m)) == '0)
    else $error("clock edge did not transfer master to slave");

  a_tff_next: assert property (@(posedge pclk) disable iff (!presetn)
    (!preload_we && |(~ck_cur & dt_r & ~rst_t))
    |=> ((master_r ^ $past(q_r ^ sum)) & $past(~ck_cur & dt_r & ~rst_t)) == '0)
    else $error("t-type master is not state xor sum");

  a_preload: assert property (@(posedge pclk) disable iff (!presetn)
    preload_we |=> q_r == ($past(pwdata[19:0]) & ~$past(rst_t)))
    else $error("preload value not taken");

  a_pin_clk: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pins.lvl[pma_pkg::PIN_CLK]) && $stable(cksel_r) && !pre_t && !preload_we
      && |(cksel_r & ~rst_t))
    |=> ((q_r ^ $past(master_r)) & $past(cksel_r & ~rst_t)) == '0)
    else $error("pin clock edge did not clock selected flop");

  a_comb_out: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((io_out_r ^ $past(pol_r) ^ $past(sum_even)) & $past(comb_r)) == '0)
    else $error("combinational pin level does not follow its sum term");

  // a frozen master is what keeps a slow clock term from racing data through
  a_master_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!preload_we && |(ck_cur & ~rst_t))
    |=> ((master_r ^ $past(master_r)) & $past(ck_cur & ~rst_t)) == '0)
    else $error("master stage moved while its clock was high");

  //////////////////////////////////////////////////////////////////////////////
  // configuration port checks

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !hit) |-> (pslverr == penable))
    else $error("unmapped access not flagged in its access phase");

  // software sees old read data until it starts another read
  a_rd_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read setup");

  a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr |=> $stable(dt_r) && $stable(cksel_r))
    else $error("flop type or clock select changed without a write");
endmodule // pma_top

// [test/pma_board.sv]
// board logic model that drives the array's clock, input and i/o pins
`timescale 1ns/1ps
module pma_board (
  input wire logic pclk,
  input wire logic clk_lvl,
  input wire logic clk_drv,
  input wire logic [10:0] in_val,
  input wire logic [10:0] in_drv,
  input wire logic [9:0] io_val,
  input wire logic [9:0] io_drv,
  input wire logic [9:0] io_out,
  input wire logic [9:0] io_oe,
  output logic pin_clk,
  output logic [10:0] in_pin,
  output logic [9:0] io_in
);
  // released wires wander every cycle, so only a working keeper hides them
  logic float_r = 1'b0;
  always_ff @(posedge pclk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    pin_clk = clk_drv ? clk_lvl : float_r;
    for (int i = 0; i < 11; i++) begin
      in_pin[i] = in_drv[i] ? in_val[i] : float_r;
    end
    for (int i = 0; i < 10; i++) begin
      io_in[i] = io_oe[i] ? io_out[i] : (io_drv[i] ? io_val[i] : float_r);
    end
  end
endmodule // pma_board

// [test/testbench.sv]
// self-checking bench for the macrocell array with a board model on its pins
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pin_clk, err;
  logic clk_lvl = 1'b0, clk_drv = 1'b1;
  logic [10:0] in_val = 11'h000, in_drv = 11'h7ff, in_pin, v;
  logic [9:0] io_val = 10'h000, io_drv = 10'h000, io_in, io_out, io_oe, pol, comb, oe, exo;
  logic [19:0] q, dt;
  logic [21:0] pins;
  int fails = 0, checked = 0, cycles = 0, seed = 32'hd26d;

  pma_top #(.KEEPER_EN(1'b1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_clk(pin_clk), .clk_driven(clk_drv),
    .in_pin(in_pin), .in_driven(in_drv), .io_in(io_in), .io_driven(io_drv),
    .io_out(io_out), .io_oe(io_oe));
  pma_board board (.pclk(pclk), .clk_lvl(clk_lvl), .clk_drv(clk_drv), .in_val(in_val),
    .in_drv(in_drv), .io_val(io_val), .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe),
    .pin_clk(pin_clk), .in_pin(in_pin), .io_in(io_in));

  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // well above the fifteen hundred or so cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK(rd, e)
  endtask

  task automatic pt_wr(input int p, input logic [41:0] t, input logic [41:0] c);
    logic [11:0] a;
    a = pma_pkg::PT_BASE + 12'(p * 16);
    apb(1'b1, a, t[31:0]);
    apb(1'b1, a + 12'h004, {22'h000000, t[41:32]});
    apb(1'b1, a + 12'h008, c[31:0]);
    apb(1'b1, a + 12'h00c, {22'h000000, c[41:32]});
  endtask

  // low long enough for the synchronisers to settle on both sides of the edge
  task automatic pulse;
    repeat (4) @(posedge pclk);
    clk_lvl <= 1'b1;
    repeat (6) @(posedge pclk);
    clk_lvl <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  function automatic logic [19:0] nxt(input logic [19:0] q0, input logic [19:0] t,
      input logic [10:0] s);
    logic [19:0] r;
    for (int f = 0; f < 20; f++) begin
      r[f] = t[f] ? q0[f] ^ s[f % 11] : s[f % 11];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(io_oe, 10'h000)
    rdc(pma_pkg::REG_DT, 32'h00000000);
    rdc(pma_pkg::REG_CKSEL, 32'h00000000);
    rdc(pma_pkg::REG_OCFG, 32'h00000000);
    rdc(pma_pkg::REG_PRELOAD, 32'h00000000);
    rdc(pma_pkg::PT_BASE + 12'haa0, pma_pkg::PT_ERASED);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, i == 0 ? 12'h002 : (i == 1 ? 12'h014 : 12'hffc), 32'h00000000);
      `CHK({pready, err, rd}, {2'b11, 32'h00000000})
    end
    for (int k = 0; k < 3; k++) begin
      pwdata <= 32'h00000000;
      q = 20'($random(seed));
      apb(1'b1, 12'(4 * k), {12'hfff, q});
      rdc(12'(4 * k), {12'h000, q});
    end
    for (int f = 0; f < 20; f++) begin
      pt_wr(12 * (f / 2) + 8 * (f % 2), 42'h1 << (1 + f % 11), 42'h0);
      pt_wr(pma_pkg::PT_CLK0 + f, 42'h1, 42'h0);
    end
    for (int n = 0; n < 12; n++) begin
      q = 20'($random(seed));
      dt = 20'($random(seed));
      v = 11'($random(seed));
      if (n == 0) dt = 20'hfffff;
      apb(1'b1, pma_pkg::REG_PRELOAD, {12'h000, q});
      apb(1'b1, pma_pkg::REG_DT, {12'h000, dt});
      apb(1'b1, pma_pkg::REG_CKSEL, 32'($random(seed)));
      in_val <= v;
      pulse();
      rdc(pma_pkg::REG_PRELOAD, {12'h000, nxt(q, dt, v)});
    end
    pt_wr(pma_pkg::PT_PRE, 42'h0, 42'h0);
    pulse();
    rdc(pma_pkg::REG_PRELOAD, 32'h000fffff);
    pt_wr(pma_pkg::PT_PRE, '1, '1);
    pt_wr(pma_pkg::PT_RST0 + 3, 42'h0, 42'h0);
    apb(1'b1, pma_pkg::REG_PRELOAD, 32'h000fffff);
    rdc(pma_pkg::REG_PRELOAD, 32'h000ffff7);
    pt_wr(pma_pkg::PT_RST0 + 3, '1, '1);
    // cell 0 even sum term now reads flop 1 back through the array
    pt_wr(0, 42'h1 << 23, 42'h0);
    for (int n = 0; n < 4; n++) begin
      q = 20'($random(seed));
      {comb, pol} = 20'($random(seed));
      oe = 10'($random(seed));
      apb(1'b1, pma_pkg::REG_PRELOAD, {12'h000, q});
      apb(1'b1, pma_pkg::REG_OCFG, {12'h000, comb, pol});
      for (int c = 0; c < 10; c++) begin
        pt_wr(pma_pkg::PT_OE0 + c, oe[c] ? 42'h0 : '1, oe[c] ? 42'h0 : '1);
        exo[c] = (comb[c] ? (c == 0 ? q[1] : in_val[(2 * c) % 11]) : q[2 * c]) ^ pol[c];
      end
      io_drv <= ~oe;
      io_val <= 10'($random(seed));
      repeat (4) @(posedge pclk);
      `CHK(io_oe, oe)
      `CHK(io_out, exo)
      pins = {(io_oe & io_out) | (~io_oe & io_val), in_val, 1'b0};
      rdc(pma_pkg::REG_PINS, {10'h000, pins});
      io_drv <= 10'h000;
      repeat (6) @(posedge pclk);
      rdc(pma_pkg::REG_PINS, {10'h000, pins});
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(io_oe, 10'h000)
    presetn <= 1'b1;
    rdc(pma_pkg::REG_PRELOAD, 32'h00000000);
    wrap_up();
  end
endmodule // testbench
